// ===== hw/sdi_anc_packet_inserter.sv
// Ancillary packet insertion engine with its APB register file
//
// What this block does
// - Mode bit low separate, high concatenated
// - Four lines, each HANC or VANC
// - Separate mode caps each line at 128
// - Concatenated mode caps one line at 512
// - Concatenated mode uses first-line registers only
// - Line numbers and counts reset to zero
// - Payload bank spans indices 040h to BFFh
// - Two bytes per location, read in order
// - Bytes expand to 10-bit packet words
// - HD luma or chroma chosen per line
// - Level A stream one or two per line
// - HANC starts at first free location
// - HANC stops at SAV start or done
// - VANC starts right after SAV ends
// - VANC stops at EAV start or done
// - Level B picks Y/C of either stream
// - Bit 14 picks luma or chroma
// - Stream one/two bits live at 02Dh
// - Insert only with both pins and enable
// - Rewrite checksum unless in protected range
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
module sdi_anc_packet_inserter (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [aux_insert_disable_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic io_processing_enable_pin,
  input wire logic video_processing_mode_pin,
  input wire logic rate_select_low_bit,
  input wire logic rate_select_high_bit,
  input wire logic levelBSelect,
  input wire logic [aux_insert_disable_pkg::LINE_NUM_W-1:0] lineNumber,
  input wire logic eavStart,
  input wire logic eavEnd,
  input wire logic savStart,
  input wire logic savEnd,
  input wire logic hancOccupied,
  input wire logic [3:0][9:0] videoIn,
  output logic [3:0][9:0] videoOut,
  output logic insertActive
);
  import aux_insert_disable_pkg::*;

  // ==========================================================
  // Register state
  logic [LINE_NUM_W-1:0] lineNum_reg [NUM_SLOTS];
  logic [15:0] lineCfg_reg [NUM_SLOTS];
  logic [3:0] streamSel_reg;
  logic [2:0] ctrl_reg;
  logic [CFG_COUNT_W-1:0] lastCount_reg;
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  // ==========================================================
  // Engine state
  eng_state_e state_reg;
  eng_state_e state_next;
  logic [CFG_COUNT_W-1:0] total_reg;
  logic [CFG_COUNT_W-1:0] done_reg;
  logic [CFG_COUNT_W-1:0] base_reg;
  logic [1:0] lane_reg;
  logic vanc_reg;
  logic [3:0][9:0] videoOut_reg;
  logic insertActive_reg;

  anc_bank_if bank();
  logic [9:0] word10;

  // ==========================================================
  // Helper functions
  function automatic logic [IDX_W-1:0] regIndex(input logic [APB_ADDR_W-1:0] a);
    regIndex = a[APB_ADDR_W-1:2];
  endfunction

  function automatic logic isBankIdx(input logic [IDX_W-1:0] idx);
    isBankIdx = (idx >= IDX_BANK_FIRST) && (idx <= IDX_BANK_LAST);
  endfunction

  function automatic logic [CFG_COUNT_W-1:0] clampCount(input logic [15:0] cfg,
                                                        input logic [CFG_COUNT_W-1:0] limit);
    logic [CFG_COUNT_W-1:0] c;
    c = cfg[CFG_COUNT_W-1:0];
    clampCount = (c > limit) ? limit : c;
  endfunction

  // Slot number and config flag of a line register; returns 0 on a miss
  function automatic logic slotOf(input logic [IDX_W-1:0] idx, output logic [1:0] slot,
                                  output logic isCfg);
    logic [IDX_W-1:0] rel;
    rel = idx - IDX_FIRST_LINE_NUMBER;
    slot = rel[2:1];
    isCfg = rel[0];
    slotOf = (idx >= IDX_FIRST_LINE_NUMBER) && (idx <= IDX_FOURTH_LINE_CONFIG);
  endfunction

  // ==========================================================
  // APB decode
  logic [IDX_W-1:0] idx;
  logic [1:0] idxSlot;
  logic idxIsCfg;
  logic idxIsLine;
  logic idxMapped;
  logic setupAccess;
  logic commit;
  logic [15:0] readValue;
  logic [15:0] wrMerged;

  always_comb begin
    idx = regIndex(paddr);
    idxIsLine = slotOf(idx, idxSlot, idxIsCfg);
    idxMapped = idxIsLine || isBankIdx(idx) || (idx == IDX_DATA_STREAM_SELECT) ||
                (idx == IDX_PROCESSING_CONTROL) || (idx == IDX_INSERT_STATUS);
    setupAccess = psel && penable && !pready_reg;
    commit = psel && penable && pready_reg;
    readValue = 16'h0000;
    if (idxIsLine) begin
      readValue = idxIsCfg ? lineCfg_reg[idxSlot] : {5'h00, lineNum_reg[idxSlot]};
    end else if (isBankIdx(idx)) begin
      readValue = bank.hostData;
    end else if (idx == IDX_DATA_STREAM_SELECT) begin
      readValue = {12'h000, streamSel_reg};
    end else if (idx == IDX_PROCESSING_CONTROL) begin
      readValue = {13'h0000, ctrl_reg};
    end else if (idx == IDX_INSERT_STATUS) begin
      readValue[STAT_BUSY_BIT] = insertActive_reg;
      readValue[STAT_COUNT_LSB +: CFG_COUNT_W] = lastCount_reg;
    end
    wrMerged = {pstrb[1] ? pwdata[15:8] : readValue[15:8], pstrb[0] ? pwdata[7:0] : readValue[7:0]};
  end

  // One wait state on every access; answer is loaded as pready rises
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setupAccess;
      pslverr_reg <= setupAccess && !idxMapped;
      if (setupAccess) begin
        prdata_reg <= pwrite ? 32'h0000_0000 : {16'h0000, readValue};
      end
    end
  end

  // ==========================================================
  // Register writes
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        lineNum_reg[i] <= LINE_REG_RESET[LINE_NUM_W-1:0];
        lineCfg_reg[i] <= LINE_REG_RESET;
      end
      streamSel_reg <= STREAM_SEL_RESET;
      ctrl_reg <= CTRL_RESET;
    end else if (commit && pwrite) begin
      if (idxIsLine && idxIsCfg) begin
        lineCfg_reg[idxSlot] <= wrMerged;
      end else if (idxIsLine) begin
        lineNum_reg[idxSlot] <= wrMerged[LINE_NUM_W-1:0];
      end else if (idx == IDX_DATA_STREAM_SELECT) begin
        streamSel_reg <= wrMerged[3:0];
      end else if (idx == IDX_PROCESSING_CONTROL) begin
        ctrl_reg <= wrMerged[2:0];
      end
    end
  end

  // ==========================================================
  // Payload bank
  always_comb begin
    bank.wrEn = commit && pwrite && isBankIdx(idx);
    bank.wrIdx = idx - IDX_BANK_FIRST;
    bank.wrData = wrMerged;
    bank.hostIdx = isBankIdx(idx) ? (idx - IDX_BANK_FIRST) : 12'h000;
  end

  anc_payload_bank #(
    .DEPTH(BANK_DEPTH)
  ) u_bank (
    .ref_clk(ref_clk),
    .bank(bank)
  );

  // ==========================================================
  // Line match and slot selection
  logic concatMode;
  logic insertEnable;
  logic [NUM_SLOTS-1:0] hit;
  logic [CFG_COUNT_W-1:0] slotCount [NUM_SLOTS];
  logic [CFG_COUNT_W-1:0] slotBase [NUM_SLOTS];
  logic anyHit;
  logic [1:0] pick;
  logic [1:0] pickLane;
  logic pickC;
  logic pickTwo;

  always_comb begin
    concatMode = ctrl_reg[CTRL_MODE_BIT];
    insertEnable = io_processing_enable_pin && video_processing_mode_pin &&
                   !ctrl_reg[CTRL_INS_DIS_BIT] && !rate_select_low_bit;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      hit[i] = (lineNum_reg[i] != '0) && (lineNum_reg[i] == lineNumber);
      slotCount[i] = clampCount(lineCfg_reg[i], SEP_WORD_LIMIT);
    end
    if (concatMode) begin
      hit[NUM_SLOTS-1:1] = '0;
      slotCount[0] = clampCount(lineCfg_reg[0], CONCAT_WORD_LIMIT);
    end
    slotBase[0] = '0;
    for (int i = 1; i < NUM_SLOTS; i++) begin
      slotBase[i] = slotBase[i-1] + slotCount[i-1];
    end
    anyHit = |hit;
    pick = 2'd0;
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (hit[i]) begin
        pick = 2'(i);
      end
    end
    pickC = lineCfg_reg[pick][CFG_STREAM_C_BIT];
    pickTwo = streamSel_reg[pick];
    if (!rate_select_high_bit) begin
      pickLane = {1'b0, pickC};
    end else if (levelBSelect) begin
      pickLane = {pickTwo, pickC};
    end else begin
      pickLane = {pickTwo, 1'b0};
    end
  end

  // ==========================================================
  // Insertion sequencing
  logic doWrite;
  logic lastWord;
  logic arm;
  logic [CFG_COUNT_W-1:0] byteAddr;

  always_comb begin
    arm = eavEnd && insertEnable && anyHit && (slotCount[pick] != '0);
    lastWord = (done_reg + 10'd1) == total_reg;
    doWrite = 1'b0;
    state_next = state_reg;
    case (state_reg)
      ENG_IDLE: begin
        if (arm) begin
          state_next = lineCfg_reg[pick][CFG_VANC_BIT] ? ENG_WAIT_VANC : ENG_WAIT_HANC;
        end
      end
      ENG_WAIT_HANC: begin
        if (savStart) begin
          state_next = ENG_IDLE;
        end else if (!hancOccupied) begin
          doWrite = 1'b1;
          state_next = lastWord ? ENG_IDLE : ENG_INSERT;
        end
      end
      ENG_WAIT_VANC: begin
        if (savEnd) begin
          state_next = ENG_INSERT;
        end
      end
      ENG_INSERT: begin
        if ((!vanc_reg && savStart) || (vanc_reg && eavStart)) begin
          state_next = ENG_IDLE;
        end else begin
          doWrite = 1'b1;
          state_next = lastWord ? ENG_IDLE : ENG_INSERT;
        end
      end
      default: begin
        state_next = ENG_IDLE;
      end
    endcase
    // Dropping enable mid-line abandons the rest of the packet
    if (!insertEnable) begin
      doWrite = 1'b0;
      state_next = ENG_IDLE;
    end
    byteAddr = base_reg + done_reg;
    bank.rdIdx = {3'h0, byteAddr[CFG_COUNT_W-1:1]};
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= ENG_IDLE;
      total_reg <= '0;
      done_reg <= '0;
      base_reg <= '0;
      lane_reg <= 2'd0;
      vanc_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ENG_IDLE && arm) begin
        total_reg <= slotCount[pick];
        base_reg <= concatMode ? '0 : slotBase[pick];
        lane_reg <= pickLane;
        vanc_reg <= lineCfg_reg[pick][CFG_VANC_BIT];
        done_reg <= '0;
      end else if (doWrite) begin
        done_reg <= done_reg + 10'd1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lastCount_reg <= '0;
    end else if (state_reg != ENG_IDLE && state_next == ENG_IDLE) begin
      lastCount_reg <= doWrite ? done_reg + 10'd1 : done_reg;
    end
  end

  // ==========================================================
  // Word formatting and video merge
  anc_word_formatter u_fmt (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clear(state_reg == ENG_IDLE),
    .advance(doWrite),
    .csumDisable(ctrl_reg[CTRL_PACKET_CHECKSUM_WORD_DIS_BIT]),
    .userByte(byteAddr[0] ? bank.rdData[15:8] : bank.rdData[7:0]),
    .word10(word10)
  );

  // Untouched lanes pass through with the same one-cycle delay
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      videoOut_reg <= '0;
      insertActive_reg <= 1'b0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        videoOut_reg[k] <= (doWrite && lane_reg == 2'(k)) ? word10 : videoIn[k];
      end
      insertActive_reg <= doWrite;
    end
  end

  assign pready = pready_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign videoOut = videoOut_reg;
  assign insertActive = insertActive_reg;
endmodule

// ===== hw/aux_insert_disable_pkg.sv
// Shared constants and types for the ancillary data inserter
package aux_insert_disable_pkg;
  // ==========================================================
  // Bus geometry
  localparam int APB_ADDR_W = 14;
  localparam int IDX_W = 12;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [IDX_W-1:0] IDX_FIRST_LINE_NUMBER = 12'h025;
  localparam logic [IDX_W-1:0] IDX_FIRST_LINE_CONFIG = 12'h026;
  localparam logic [IDX_W-1:0] IDX_SECOND_LINE_NUMBER = 12'h027;
  localparam logic [IDX_W-1:0] IDX_SECOND_LINE_CONFIG = 12'h028;
  localparam logic [IDX_W-1:0] IDX_THIRD_INSERT_LINE_NUMBER = 12'h029;
  localparam logic [IDX_W-1:0] IDX_THIRD_LINE_CONFIG = 12'h02a;
  localparam logic [IDX_W-1:0] IDX_FOURTH_INSERT_LINE_NUMBER = 12'h02b;
  localparam logic [IDX_W-1:0] IDX_FOURTH_LINE_CONFIG = 12'h02c;
  localparam logic [IDX_W-1:0] IDX_DATA_STREAM_SELECT = 12'h02d;
  localparam logic [IDX_W-1:0] IDX_PROCESSING_CONTROL = 12'h010;
  localparam logic [IDX_W-1:0] IDX_INSERT_STATUS = 12'h011;
  localparam logic [IDX_W-1:0] IDX_BANK_FIRST = 12'h040;
  localparam logic [IDX_W-1:0] IDX_BANK_LAST = 12'hbff;
  localparam int BANK_DEPTH = 3008;
  // ==========================================================
  // Field layout
  localparam int LINE_NUM_W = 11;
  localparam int CFG_COUNT_W = 10;
  localparam int CFG_VANC_BIT = 13;
  localparam int CFG_STREAM_C_BIT = 14;
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_INS_DIS_BIT = 1;
  localparam int CTRL_PACKET_CHECKSUM_WORD_DIS_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_COUNT_LSB = 4;
  // ==========================================================
  // Reset values and limits
  localparam logic [15:0] LINE_REG_RESET = 16'h0000;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [3:0] STREAM_SEL_RESET = 4'h0;
  localparam int NUM_SLOTS = 4;
  localparam logic [CFG_COUNT_W-1:0] SEP_WORD_LIMIT = 10'd128;
  localparam logic [CFG_COUNT_W-1:0] CONCAT_WORD_LIMIT = 10'd512;
  // ==========================================================
  // Packet layout
  localparam int ADF_WORDS = 3;
  localparam int DC_POS = 5;
  localparam int UDW_FIRST_POS = 6;
  typedef enum {ENG_IDLE, ENG_WAIT_HANC, ENG_WAIT_VANC, ENG_INSERT} eng_state_e;
endpackage

// ===== hw/anc_bank_if.sv
// Port bundle between the inserter and its payload bank
`timescale 1ns/100ps
interface anc_bank_if;
  logic wrEn;
  logic [11:0] wrIdx;
  logic [15:0] wrData;
  logic [11:0] hostIdx;
  logic [15:0] hostData;
  logic [11:0] rdIdx;
  logic [15:0] rdData;
  modport owner(input wrEn, input wrIdx, input wrData, input hostIdx, input rdIdx, output hostData, output rdData);
  modport user(output wrEn, output wrIdx, output wrData, output hostIdx, output rdIdx, input hostData, input rdData);
endinterface

// ===== hw/anc_payload_bank.sv
// Host-written payload bank with one write port and two read ports
`timescale 1ns/100ps
module anc_payload_bank #(
  parameter int DEPTH = aux_insert_disable_pkg::BANK_DEPTH
) (
  input wire logic ref_clk,
  anc_bank_if.owner bank
);
  import aux_insert_disable_pkg::*;
  // ==========================================================
  // Storage
  // Contents are not reset; software loads the bank before enabling
  logic [15:0] mem [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (bank.wrEn) begin
      mem[bank.wrIdx] <= bank.wrData;
    end
  end

  assign bank.hostData = mem[bank.hostIdx];
  assign bank.rdData = mem[bank.rdIdx];
endmodule

// ===== hw/anc_word_formatter.sv
// Expands user bytes into 10-bit packet words and fixes the checksum
`timescale 1ns/100ps
module anc_word_formatter (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic advance,
  input wire logic csumDisable,
  input wire logic [7:0] userByte,
  output logic [9:0] word10
);
  import aux_insert_disable_pkg::*;
  logic [9:0] pos_reg;
  logic [7:0] count_reg;
  logic [8:0] sum_reg;
  logic [9:0] expanded;
  logic isCsum;
  logic isProtected;

  // ==========================================================
  // Word expansion
  function automatic logic [9:0] parityExpand(input logic [7:0] b);
    parityExpand = {~(^b), ^b, b};
  endfunction

  always_comb begin
    isCsum = (pos_reg == ({2'b00, count_reg} + 10'(UDW_FIRST_POS)));
    isProtected = (userByte <= 8'h03) || (userByte >= 8'hfc);
    if (pos_reg < 10'(ADF_WORDS) || (isCsum && isProtected)) begin
      expanded = {{2{userByte[7]}}, userByte};
    end else begin
      expanded = parityExpand(userByte);
    end
    if (isCsum && !csumDisable && !isProtected) begin
      word10 = {~sum_reg[8], sum_reg};
    end else begin
      word10 = expanded;
    end
  end

  // ==========================================================
  // Packet position and running sum
  always_ff @(posedge ref_clk) begin
    if (sys_rst || clear) begin
      pos_reg <= 10'h000;
      count_reg <= 8'h00;
      sum_reg <= 9'h000;
    end else if (advance) begin
      if (isCsum) begin
        pos_reg <= 10'h000;
        sum_reg <= 9'h000;
      end else begin
        pos_reg <= pos_reg + 10'h001;
        if (pos_reg >= 10'(ADF_WORDS)) begin
          sum_reg <= sum_reg + word10[8:0];
        end
        if (pos_reg == 10'(DC_POS)) begin
          count_reg <= userByte;
        end
      end
    end
  end
endmodule

// ===== testbench/video_source_model.sv
// Upstream video source: line timing, timing-reference pulses and lane data
`timescale 1ns/100ps
module video_source_model #(
  parameter int HANC_LEN = 140,
  parameter int OCC_LEN = 3
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [10:0] actLen,
  output logic [10:0] pos,
  output logic [10:0] lineNumber,
  output logic eavStart,
  output logic eavEnd,
  output logic savStart,
  output logic savEnd,
  output logic hancOccupied,
  output logic [3:0][9:0] videoIn
);
  // ==========================================================
  // Line counter; lines run 1 to 15 so slots can target them
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      pos <= 11'h000;
      lineNumber <= 11'h001;
    end else if (pos == 11'(HANC_LEN + 7) + actLen) begin
      pos <= 11'h000;
      lineNumber <= (lineNumber == 11'h00f) ? 11'h001 : lineNumber + 11'h001;
    end else begin
      pos <= pos + 11'h001;
    end
  end
  // ==========================================================
  // Timing pulses and data
  assign eavStart = (pos == 11'h000);
  assign eavEnd = (pos == 11'h003);
  assign savStart = (pos == 11'(HANC_LEN + 4));
  assign savEnd = (pos == 11'(HANC_LEN + 7));
  // Packets already present at the head of blanking
  assign hancOccupied = (pos >= 11'h004) && (pos < 11'(4 + OCC_LEN));
  // Lane data changes every cycle so a stale word cannot pass as fresh
  always_comb begin
    for (int l = 0; l < 4; l++) begin
      videoIn[l] = {pos[7:0], 2'(l)};
    end
  end
endmodule

// ===== testbench/anc_insert_monitor.sv
// Port-level checker for the ancillary packet inserter
`timescale 1ns/100ps
module anc_insert_checker (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic io_processing_enable_pin,
  input wire logic video_processing_mode_pin,
  input wire logic rate_select_low_bit,
  input wire logic eavStart,
  input wire logic eavEnd,
  input wire logic savStart,
  input wire logic savEnd,
  input wire logic hancOccupied,
  input wire logic [3:0][9:0] videoIn,
  input wire logic [3:0][9:0] videoOut,
  input wire logic insertActive
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Run length of inserted words
  logic [10:0] runLen_reg;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      runLen_reg <= 11'h000;
    end else begin
      runLen_reg <= insertActive ? runLen_reg + 11'h001 : 11'h000;
    end
  end
  // ==========================================================
  // Assertions
  apb_one_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("pready not after exactly one wait state");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  ready_in_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
  write_rdata_a: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("prdata not zero on write");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  gate_idle_a: assert property (
    (!io_processing_enable_pin || !video_processing_mode_pin || rate_select_low_bit) [*2] |=> !insertActive)
    else $error("insertion while gated off");
  trs_gap_a: assert property (eavStart || eavEnd || savStart || savEnd |=> !insertActive)
    else $error("inserted word over timing reference");
  occupied_skip_a: assert property (eavEnd ##1 hancOccupied |=> !insertActive)
    else $error("insertion over existing packet");
  passthru_a: assert property (!insertActive && !$past(sys_rst) |-> videoOut == $past(videoIn))
    else $error("video not passed through");
  run_cap_a: assert property (insertActive |-> runLen_reg < 11'h200) else $error("more than 512 words");
  cover property (insertActive && !$past(insertActive));
  cover property (pslverr);
  cover property (pready && !pwrite);
endmodule

bind sdi_anc_packet_inserter anc_insert_checker chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .io_processing_enable_pin(io_processing_enable_pin), .video_processing_mode_pin(video_processing_mode_pin),
  .rate_select_low_bit(rate_select_low_bit), .eavStart(eavStart), .eavEnd(eavEnd), .savStart(savStart),
  .savEnd(savEnd), .hancOccupied(hancOccupied), .videoIn(videoIn), .videoOut(videoOut), .insertActive(insertActive));

// ===== testbench/sdi_anc_packet_inserter_tb.sv
// Self-checking bench for the ancillary packet inserter
`timescale 1ns/100ps
module sdi_anc_packet_inserter_tb;
  import aux_insert_disable_pkg::*;
  // ==========================================================
  // Signals
  localparam int HL = 140;
  typedef struct {bit cc; int slot; bit vanc; bit c; bit ds2; bit hi; bit lb; int cnt; int act; int gate; int n;} row_s;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [APB_ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h3;
  logic pready, pslverr, insertActive, eavStart, eavEnd, savStart, savEnd, hancOccupied;
  logic [31:0] prdata;
  logic ioEn = 1'b1, modePin = 1'b1, rateLo = 1'b0, rateHi = 1'b0, lvlB = 1'b0;
  logic [10:0] actLen = 11'h03c;
  logic [10:0] pos, lineNumber;
  logic [3:0][9:0] videoIn, videoOut, prevIn;
  logic [9:0] w [4];
  logic bad;
  int nSeen, firstPos, expLane, nMismatch, nTests;
  // Cases: mode, slot, vanc, chroma, stream two, 3G, level B, count, active length, gate, words
  row_s rows [14] = '{'{0,0,0,0,0,0,0,6,60,0,6}, '{0,1,1,1,0,0,0,4,60,0,4}, '{0,2,0,1,1,1,0,5,60,0,5},
    '{0,3,1,1,1,1,1,7,60,0,7}, '{0,1,0,0,0,1,0,5,60,0,5}, '{0,0,0,0,0,0,0,130,60,0,128},
    '{1,0,0,0,0,0,0,200,60,0,137}, '{1,0,1,0,0,0,0,520,600,0,512}, '{0,0,1,0,0,0,0,100,60,0,60},
    '{1,1,0,0,0,0,0,6,60,0,0}, '{0,0,0,0,0,0,0,6,60,1,0}, '{0,0,0,0,0,0,0,6,60,2,0},
    '{0,0,0,0,0,0,0,6,60,3,0}, '{0,0,0,0,0,0,0,6,60,4,0}};
  always #4 ref_clk = ~ref_clk;
  sdi_anc_packet_inserter dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .io_processing_enable_pin(ioEn), .video_processing_mode_pin(modePin),
    .rate_select_low_bit(rateLo), .rate_select_high_bit(rateHi), .levelBSelect(lvlB), .lineNumber(lineNumber),
    .eavStart(eavStart), .eavEnd(eavEnd), .savStart(savStart), .savEnd(savEnd), .hancOccupied(hancOccupied),
    .videoIn(videoIn), .videoOut(videoOut), .insertActive(insertActive));
  video_source_model #(.HANC_LEN(HL)) src (.ref_clk(ref_clk), .sys_rst(sys_rst), .actLen(actLen), .pos(pos),
    .lineNumber(lineNumber), .eavStart(eavStart), .eavEnd(eavEnd), .savStart(savStart), .savEnd(savEnd),
    .hancOccupied(hancOccupied), .videoIn(videoIn));
  // ==========================================================
  // Per-line observer; counts restart at position 1 of each line
  always @(posedge ref_clk) begin
    prevIn <= videoIn;
    if (pos === 11'h001) begin
      nSeen <= 0;
      bad <= 1'b0;
    end else if (insertActive === 1'b1) begin
      if (nSeen == 0) firstPos <= pos;
      if (nSeen < 4) w[nSeen] <= videoOut[expLane];
      for (int l = 0; l < 4; l++) if (l != expLane && videoOut[l] !== prevIn[l]) bad <= 1'b1;
      nSeen <= nSeen + 1;
    end
  end
  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      nMismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [15:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    paddr <= {idx, 2'b00};
    pwrite <= wr;
    pwdata <= {16'h0000, wd};
    psel <= 1'b1;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) nMismatch++;
    @(posedge ref_clk);
  endtask
  task automatic apbWr(input logic [11:0] idx, input logic [15:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, wd, rd, err);
  endtask
  task automatic apbChk(input logic [11:0] idx, input logic [31:0] exp, input logic expErr);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, 16'h0000, rd, err);
    check("prdata", rd, exp);
    check("pslverr", 32'(err), 32'(expErr));
  endtask
  task automatic runRow(input row_s r);
    logic [10:0] tgt, nxt;
    int k;
    tgt = (lineNumber >= 11'h00e) ? lineNumber - 11'h00d : lineNumber + 11'h002;
    nxt = (tgt == 11'h00f) ? 11'h001 : tgt + 11'h001;
    expLane = r.hi ? 2 * r.ds2 + (r.lb ? r.c : 0) : r.c;
    ioEn <= (r.gate != 2);
    modePin <= (r.gate != 3);
    rateLo <= (r.gate == 4);
    rateHi <= r.hi;
    lvlB <= r.lb;
    actLen <= 11'(r.act);
    for (k = 0; k < 4; k++) begin
      // Host gives a non-zero line only to the slot under test; slot 0 keeps count 5 when another slot is tested
      apbWr(IDX_FIRST_LINE_NUMBER + 12'(2 * k), (k == r.slot) ? {5'h00, tgt} : 16'h0000);
      apbWr(IDX_FIRST_LINE_CONFIG + 12'(2 * k), (k == r.slot) ? 16'(r.cnt) | (16'(r.vanc) << CFG_VANC_BIT)
        | (16'(r.c) << CFG_STREAM_C_BIT) : (k == 0 && r.slot > 0) ? 16'h0005 : 16'h0000);
    end
    apbWr(IDX_DATA_STREAM_SELECT, 16'(r.ds2) << r.slot);
    apbWr(IDX_PROCESSING_CONTROL, 16'(r.cc) | (16'(r.gate == 1) << CTRL_INS_DIS_BIT));
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (!(lineNumber === nxt && pos === 11'h001) && k < 5000);
    check("line wait", 32'(k < 5000), 32'h1);
    check("words", nSeen, r.n);
    if (r.n > 0) begin
      check("first", firstPos, r.vanc ? HL + 9 : 8);
      check("lane", 32'(bad), 32'h0);
      check("adf", w[1], 32'h3ff);
      check("did", w[3], r.slot > 0 ? 32'h143 : 32'h241);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Two packets: one at byte 0, one at byte 5
    apbWr(IDX_BANK_FIRST, 16'hff00);
    apbWr(IDX_BANK_FIRST + 12'h001, 16'h41ff);
    apbWr(IDX_BANK_FIRST + 12'h002, 16'h0000);
    apbWr(IDX_BANK_FIRST + 12'h003, 16'hffff);
    apbWr(IDX_BANK_FIRST + 12'h004, 16'h0043);
    foreach (rows[i]) runRow(rows[i]);
    apbChk(IDX_INSERT_STATUS, 32'h000003c0, 1'b0);
    // Second reset: registers clear, bank keeps its words
    sys_rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 9; k++) apbChk(IDX_FIRST_LINE_NUMBER + 12'(k), 32'h0, 1'b0);
    apbChk(IDX_PROCESSING_CONTROL, 32'h0, 1'b0);
    apbChk(IDX_BANK_FIRST, 32'h0000ff00, 1'b0);
    apbWr(IDX_BANK_LAST, 16'hbeef);
    apbChk(IDX_BANK_LAST, 32'h0000beef, 1'b0);
    apbWr(12'hc00, 16'h1234);
    apbChk(12'hc00, 32'h0, 1'b1);
    tally_and_finish();
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    nMismatch++;
    tally_and_finish();
  end
endmodule
